// ---- cigate_cfg.svh ----
// Purpose: constants for the card interface host select gating block
// Assumes: single 200 MHz clock
// Notes: definitions only
`ifndef CIGATE_CFG_SVH
`define CIGATE_CFG_SVH
`define CIGATE_CLK_PERIOD_PS 5000
`define CIGATE_SYNC_STAGES   2
`define CIGATE_RESET_SEL_HV  1'b1
`define CIGATE_RESET_SEL_MV  1'b1
`define CIGATE_RESET_RST     1'b0
// pin synchroniser reset: only the presence-low input idles high (bit 3)
`define CIGATE_SYNC_RESET    14'h0008
// card contacts idle high on their pull-ups
`define CIGATE_CARD_IDLE     3'h7
`endif

// ---- cigate_host_model.sv ----
// Purpose: host microcontroller model that drives the control pins and the host data pins
// Assumes: requests from the bench are taken at a rising edge and launched on that same edge
// Notes: host data pins are pulled-up wires that either party may pull low
`timescale 1ns/1ps
module cigate_host_model (
	// clock
	input  wire logic                     ref_clk_i,
	// requests from the bench
	input  wire logic                     want_cs_i,
	input  wire logic                     want_pd_i,
	input  wire cigate_pkg::cigate_ctl_s  want_ctl_i,
	input  wire cigate_pkg::cigate_data_s want_data_i,
	// device side pins
	input  wire cigate_pkg::cigate_data_s dev_pull_low_i,
	output logic                          chip_select_o,
	output logic                          low_power_request_o,
	output cigate_pkg::cigate_ctl_s       ctl_o,
	output cigate_pkg::cigate_data_s      pin_level_o
);
	cigate_pkg::cigate_data_s drive;
	// pins follow the bench one edge late; the bench starts with both selects high, regulator off
	always @(posedge ref_clk_i) begin
		chip_select_o <= want_cs_i;
		low_power_request_o <= want_pd_i;
		ctl_o <= want_ctl_i;
		drive <= want_data_i;
	end
	// a released pin floats up, so its level is low only where someone pulls it
	assign pin_level_o = cigate_pkg::cigate_data_s'(drive & ~dev_pull_low_i);
endmodule // cigate_host_model

// ---- cigate_pkg.sv ----
// Purpose: types for the card interface host select gating block
// Assumes: nothing
// Notes: carrier structs only
package cigate_pkg;
	typedef struct packed {
		logic sel_high_volt;
		logic sel_mid_volt;
		logic card_reset;
	} cigate_ctl_s;
	typedef struct packed {
		logic host_card_data;
		logic host_aux_data_one;
		logic host_aux_data_two;
	} cigate_data_s;
endpackage

// ---- cigate_top.sv ----
// Purpose: host-side chip select gating of one smart card interface
// Assumes: all pin inputs asynchronous; card clock source sampled into ref_clk_i
// Notes: pull-up enables are flags for the pad ring, the pads themselves are outside
`timescale 1ns/1ps
`include "cigate_cfg.svh"
module cigate_top (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	// host control pins
	input  wire logic chip_select_i,
	input  wire logic low_power_request_i,
	input  wire logic supply_sel_high_volt_i,
	input  wire logic supply_sel_mid_volt_i,
	input  wire logic host_card_reset_in_i,
	input  wire logic card_clock_source_i,
	// host data pins, split into in, out, enable
	input  wire logic host_card_data_i,
	output logic      host_card_data_o,
	output logic      host_card_data_oe_o,
	input  wire logic host_aux_data_one_i,
	output logic      host_aux_data_one_o,
	output logic      host_aux_data_one_oe_o,
	input  wire logic host_aux_data_two_i,
	output logic      host_aux_data_two_o,
	output logic      host_aux_data_two_oe_o,
	output logic      host_data_pullup_o,
	// card side data, as seen from the card contacts
	input  wire logic card_data_i,
	input  wire logic card_aux_one_i,
	input  wire logic card_aux_two_i,
	output logic      card_data_o,
	output logic      card_aux_one_o,
	output logic      card_aux_two_o,
	output logic      card_data_dir_o,
	// card presence and status from the analog side
	input  wire logic card_inserted_detect_i,
	input  wire logic card_inserted_detect_n_i,
	input  wire logic fault_i,
	input  wire logic seq_supply_on_i,
	input  wire logic ready_i,
	// card control and presence; only the supply selects and card reset are gated
	output logic      supply_sel_high_volt_o,
	output logic      supply_sel_mid_volt_o,
	output logic      card_reset_o,
	output logic      card_clock_o,
	output logic      card_supply_en_o,
	output logic      card_present_o,
	// interrupt pins, open drain
	output logic      fault_irq_n_o,
	output logic      fault_irq_oe_o,
	output logic      fault_irq_pullup_o,
	output logic      ready_irq_n_o,
	output logic      ready_irq_oe_o,
	output logic      ready_irq_pullup_o
);
	localparam int SYNC_W = 14;

	// every pin passes two flops before use
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	wire  [SYNC_W-1:0] raw_in = {chip_select_i, low_power_request_i, supply_sel_high_volt_i,
		supply_sel_mid_volt_i, host_card_reset_in_i, card_clock_source_i, host_card_data_i,
		host_aux_data_one_i, host_aux_data_two_i, card_inserted_detect_i,
		card_inserted_detect_n_i, fault_i, seq_supply_on_i, ready_i};

	// card contacts come from outside the clock domain as well
	logic [2:0] card_sync_a;
	logic [2:0] card_sync_b;
	wire  [2:0] card_raw = {card_data_i, card_aux_one_i, card_aux_two_i};

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// flops reset to the idle pin levels, else a false card edge follows reset
			sync_a <= `CIGATE_SYNC_RESET;
			sync_b <= `CIGATE_SYNC_RESET;
			card_sync_a <= `CIGATE_CARD_IDLE;
			card_sync_b <= `CIGATE_CARD_IDLE;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			card_sync_a <= card_raw;
			card_sync_b <= card_sync_a;
		end
	end

	wire cs_s   = sync_b[13];
	wire pwd_s  = sync_b[12];
	wire clk_s  = sync_b[8];
	wire card_inserted_detect_p = sync_b[4];
	wire card_inserted_detect_n = sync_b[3];
	wire flt_s  = sync_b[2];
	wire sup_s  = sync_b[1];
	wire rdy_s  = sync_b[0];
	wire card_dat_s = card_sync_b[2];
	wire card_a1_s  = card_sync_b[1];
	wire card_a2_s  = card_sync_b[0];
	cigate_pkg::cigate_ctl_s  live_ctl;
	cigate_pkg::cigate_data_s host_dat;
	assign live_ctl = '{sync_b[11], sync_b[10], sync_b[9]};
	assign host_dat = '{sync_b[7], sync_b[6], sync_b[5]};

	// latch holds the last value seen while selected
	cigate_pkg::cigate_ctl_s held_ctl;
	cigate_pkg::cigate_ctl_s next_ctl;
	assign next_ctl = cs_s ? live_ctl : held_ctl;

	// presence: either polarity counts, unused input tied inactive
	wire present = card_inserted_detect_p | ~card_inserted_detect_n;
	logic present_q;
	logic change_flag;
	// presence change is sticky until the card state is seen stable while selected
	wire  clear_change = cs_s & (present == present_q) & change_flag;
	wire  irq_active = flt_s | change_flag;

	wire selected = cs_s;
	wire pull_on = selected & ~pwd_s;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			held_ctl <= '{`CIGATE_RESET_SEL_HV, `CIGATE_RESET_SEL_MV, `CIGATE_RESET_RST};
			present_q <= 1'b0;
			change_flag <= 1'b0;
		end else begin
			held_ctl <= next_ctl;
			present_q <= present;
			// a new change wins over the clear
			change_flag <= (present != present_q) | (change_flag & ~clear_change);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			supply_sel_high_volt_o <= `CIGATE_RESET_SEL_HV;
			supply_sel_mid_volt_o <= `CIGATE_RESET_SEL_MV;
			card_reset_o <= `CIGATE_RESET_RST;
		end else begin
			supply_sel_high_volt_o <= next_ctl.sel_high_volt;
			supply_sel_mid_volt_o <= next_ctl.sel_mid_volt;
			card_reset_o <= next_ctl.card_reset;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			card_clock_o <= 1'b0;
			card_supply_en_o <= 1'b0;
			card_present_o <= 1'b0;
		end else begin
			card_clock_o <= clk_s;
			card_supply_en_o <= sup_s;
			card_present_o <= present;
		end
	end

	// data path: host to card while selected; card side pulls host pins low while selected, whenever its contact is low
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			card_data_o <= 1'b1;
			card_aux_one_o <= 1'b1;
			card_aux_two_o <= 1'b1;
			card_data_dir_o <= 1'b0;
			host_card_data_o <= 1'b0;
			host_aux_data_one_o <= 1'b0;
			host_aux_data_two_o <= 1'b0;
			host_card_data_oe_o <= 1'b0;
			host_aux_data_one_oe_o <= 1'b0;
			host_aux_data_two_oe_o <= 1'b0;
			host_data_pullup_o <= 1'b1;
		end else begin
			card_data_o <= selected ? host_dat.host_card_data : 1'b1;
			card_aux_one_o <= selected ? host_dat.host_aux_data_one : 1'b1;
			card_aux_two_o <= selected ? host_dat.host_aux_data_two : 1'b1;
			card_data_dir_o <= selected;
			// only pull low toward host, a weak pull-up makes the high
			host_card_data_o <= 1'b0;
			host_aux_data_one_o <= 1'b0;
			host_aux_data_two_o <= 1'b0;
			host_card_data_oe_o <= selected & ~card_dat_s;
			host_aux_data_one_oe_o <= selected & ~card_a1_s;
			host_aux_data_two_oe_o <= selected & ~card_a2_s;
			host_data_pullup_o <= 1'b1;
		end
	end

	// interrupts: never drive high, only enable a low
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault_irq_n_o <= 1'b0;
			fault_irq_oe_o <= 1'b0;
			fault_irq_pullup_o <= 1'b0;
			ready_irq_n_o <= 1'b0;
			ready_irq_oe_o <= 1'b0;
			ready_irq_pullup_o <= 1'b0;
		end else begin
			fault_irq_n_o <= 1'b0;
			fault_irq_oe_o <= selected & irq_active;
			fault_irq_pullup_o <= pull_on;
			ready_irq_n_o <= 1'b0;
			ready_irq_oe_o <= selected & ~rdy_s;
			ready_irq_pullup_o <= pull_on;
		end
	end

	a_irq_never_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		fault_irq_oe_o |-> !fault_irq_n_o) else $error("interrupt driven high");
	a_desel_no_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!cs_s |=> !fault_irq_oe_o && !ready_irq_oe_o) else $error("low while deselected");
	a_desel_pull_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(!cs_s || pwd_s) |=> !fault_irq_pullup_o && !ready_irq_pullup_o) else $error("pull-up on");
	a_pull_on_sel: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(cs_s && !pwd_s) |=> fault_irq_pullup_o) else $error("pull-up missing");
	a_hold_while_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(!cs_s && $past(!cs_s)) |=> $stable(card_reset_o) && $stable(supply_sel_high_volt_o))
		else $error("latched value moved");
	a_pass_when_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cs_s |=> card_reset_o == $past(live_ctl.card_reset)) else $error("reset not passed");
	a_transparent_again: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(cs_s) |=> supply_sel_mid_volt_o == $past(live_ctl.sel_mid_volt)) else $error("not transparent");
	a_desel_no_data: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!cs_s |=> !host_card_data_oe_o && card_data_o) else $error("data passed deselected");
	a_presence_map: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		1'b1 |=> card_present_o == $past(card_inserted_detect_p || !card_inserted_detect_n)) else $error("card presence wrong");
	a_clock_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		1'b1 |=> card_clock_o == $past(clk_s)) else $error("clock not followed");
	a_supply_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		1'b1 |=> card_supply_en_o == $past(sup_s)) else $error("supply not followed");
endmodule // cigate_top

// ---- cigate_top_tb.sv ----
// Purpose: self-checking bench for the chip select gating block
// Assumes: outputs settle within eight edges of a host request, card echo included
// Notes: random steps with fixed seed, plus presence and reset corners
`timescale 1ns/1ps
`include "cigate_cfg.svh"
module cigate_top_tb;
	logic ref_clk_i, rstn_i, want_cs, want_pd, cs, pd, clk_src, det, det_n, fault, seq_on, rdy, c, seen;
	cigate_pkg::cigate_ctl_s want_ctl, ctl, held;
	cigate_pkg::cigate_data_s want_data, pin, card_in;
	wire cigate_pkg::cigate_data_s h_o, h_oe, card_out;
	wire cigate_pkg::cigate_ctl_s gated;
	wire logic card_dir, hpu, clk_o, sup_en, card_inserted_detect, f_n, f_oe, f_pu, r_n, r_oe, r_pu;
	int err_total, checks_done, i;
	cigate_host_model u_host (.ref_clk_i(ref_clk_i), .want_cs_i(want_cs), .want_pd_i(want_pd), .want_ctl_i(want_ctl),
		.want_data_i(want_data), .dev_pull_low_i(cigate_pkg::cigate_data_s'(h_oe & ~h_o)), .chip_select_o(cs),
		.low_power_request_o(pd), .ctl_o(ctl), .pin_level_o(pin));
	cigate_top DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .chip_select_i(cs), .low_power_request_i(pd),
		.supply_sel_high_volt_i(ctl.sel_high_volt), .supply_sel_mid_volt_i(ctl.sel_mid_volt),
		.host_card_reset_in_i(ctl.card_reset), .card_clock_source_i(clk_src),
		.host_card_data_i(pin.host_card_data), .host_card_data_o(h_o.host_card_data),
		.host_card_data_oe_o(h_oe.host_card_data), .host_aux_data_one_i(pin.host_aux_data_one),
		.host_aux_data_one_o(h_o.host_aux_data_one), .host_aux_data_one_oe_o(h_oe.host_aux_data_one),
		.host_aux_data_two_i(pin.host_aux_data_two), .host_aux_data_two_o(h_o.host_aux_data_two),
		.host_aux_data_two_oe_o(h_oe.host_aux_data_two), .host_data_pullup_o(hpu),
		.card_data_i(card_in.host_card_data), .card_aux_one_i(card_in.host_aux_data_one),
		.card_aux_two_i(card_in.host_aux_data_two), .card_data_o(card_out.host_card_data),
		.card_aux_one_o(card_out.host_aux_data_one), .card_aux_two_o(card_out.host_aux_data_two),
		.card_data_dir_o(card_dir), .card_inserted_detect_i(det), .card_inserted_detect_n_i(det_n), .fault_i(fault),
		.seq_supply_on_i(seq_on), .ready_i(rdy), .supply_sel_high_volt_o(gated.sel_high_volt),
		.supply_sel_mid_volt_o(gated.sel_mid_volt), .card_reset_o(gated.card_reset), .card_clock_o(clk_o),
		.card_supply_en_o(sup_en), .card_present_o(card_inserted_detect), .fault_irq_n_o(f_n), .fault_irq_oe_o(f_oe),
		.fault_irq_pullup_o(f_pu), .ready_irq_n_o(r_n), .ready_irq_oe_o(r_oe), .ready_irq_pullup_o(r_pu));
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	function automatic cigate_pkg::cigate_ctl_s exp_ctl(input logic s, input cigate_pkg::cigate_ctl_s live, held_v);
		return s ? live : held_v;
	endfunction
	task automatic chk(input logic [2:0] seen_v, input logic [2:0] exp_v);
		checks_done++;
		if (seen_v !== exp_v) begin
			err_total++;
			$display("[FAIL] %0t seen %b expected %b", $time, seen_v, exp_v);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic step(input logic s, input cigate_pkg::cigate_ctl_s v);
		logic r;
		logic pos;
		cigate_pkg::cigate_data_s oe_x;
		@(posedge ref_clk_i);
		r = 1'($urandom);
		pos = 1'($urandom);
		if (want_cs && !s) held = want_ctl;
		want_cs <= s;
		want_ctl <= v;
		want_pd <= 1'($urandom);
		want_data <= cigate_pkg::cigate_data_s'(3'($urandom));
		card_in <= cigate_pkg::cigate_data_s'(3'($urandom));
		// only one presence input is in use at a time, the other sits inactive
		det <= pos & r;
		det_n <= ~(~pos & r);
		fault <= 1'($urandom);
		seq_on <= 1'($urandom);
		rdy <= 1'($urandom);
		clk_src <= 1'($urandom);
		repeat (9) @(posedge ref_clk_i);
		#1;
		oe_x = want_cs ? ~card_in : 3'h0;
		chk(gated, exp_ctl(want_cs, want_ctl, held));
		chk(h_oe, oe_x);
		chk(h_o, 3'h0);
		chk(card_out, want_cs ? (want_data & ~oe_x) : 3'h7);
		chk({2'h0, card_dir}, {2'h0, want_cs});
		chk({2'h0, hpu}, 3'h1);
		chk({1'b0, f_pu, r_pu}, {1'b0, {2{want_cs & ~want_pd}}});
		chk({1'b0, f_oe, r_oe}, {1'b0, want_cs & fault, want_cs & ~rdy});
		chk({1'b0, f_n, r_n}, 3'h0);
		chk({2'h0, card_inserted_detect}, {2'h0, det | ~det_n});
		chk({1'b0, clk_o, sup_en}, {1'b0, clk_src, seq_on});
	endtask
	initial begin
		{want_cs, want_pd, det, det_n, fault, seq_on, rdy, clk_src} = 8'h89;
		want_ctl = cigate_pkg::cigate_ctl_s'(3'h6);
		want_data = cigate_pkg::cigate_data_s'(3'h7);
		card_in = cigate_pkg::cigate_data_s'(3'h7);
		held = {`CIGATE_RESET_SEL_HV, `CIGATE_RESET_SEL_MV, `CIGATE_RESET_RST};
		err_total = 0;
		checks_done = 0;
		rstn_i = 1'b0;
		void'($urandom(32'h39c091ec));
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk(gated, held);
		chk(card_out, 3'h7);
		chk({1'b0, f_oe, r_oe}, 3'h0);
		@(posedge ref_clk_i);
		rstn_i <= 1'b1;
		for (i = 0; i < 4; i++) step(1'b1, cigate_pkg::cigate_ctl_s'(3'(i * 2)));
		for (i = 0; i < 150; i++) begin
			c = 1'($urandom);
			if (want_cs && !c) step(1'b0, want_ctl);
			step(c, cigate_pkg::cigate_ctl_s'(3'($urandom)));
		end
		// reset in mid-run: outputs go idle at once and the latch forgets what it held
		@(posedge ref_clk_i);
		rstn_i <= 1'b0;
		held = {`CIGATE_RESET_SEL_HV, `CIGATE_RESET_SEL_MV, `CIGATE_RESET_RST};
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk(gated, held);
		chk(card_out, 3'h7);
		chk({1'b0, f_oe, r_oe}, 3'h0);
		@(posedge ref_clk_i);
		rstn_i <= 1'b1;
		step(want_cs, want_ctl);
		// a presence edge while selected must reach the interrupt even without a fault
		@(posedge ref_clk_i);
		{want_cs, fault, det, det_n} <= 4'h9;
		repeat (8) @(posedge ref_clk_i);
		det <= 1'b1;
		seen = 1'b0;
		repeat (8) begin
			@(posedge ref_clk_i);
			#1 seen = seen | f_oe;
		end
		chk({2'h0, seen}, 3'h1);
		end_of_test;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_total++;
		end_of_test;
	end
endmodule // cigate_top_tb
